// ---- asp_fifo.sv ----
// small first-in first-out buffer for finished conversion words
// assumes one clock, synchronous active-high reset, and a flush input that empties it at once
`timescale 1ns/10ps

module asp_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic flush_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [$clog2(DEPTH+1)-1:0] level_o
);
   // ----------------------------------------
   // storage and pointers
   // ----------------------------------------
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   // depth must be a power of two so pointers wrap by themselves
   initial
   begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
         $error("asp_fifo: DEPTH must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];     // word store
   logic [AW-1:0] wr_ptr;             // next slot to write
   logic [AW-1:0] rd_ptr;             // next slot to read
   logic [CW-1:0] count;              // words in the store, not counting the output register
   logic push;
   logic load;

   // full is honest: the output register is separate, so a full store refuses
   assign push = in_valid_i && in_ready_o;
   // read data come out of a register, refilled when empty or taken
   assign load = (count != '0) && (!out_valid_o || out_ready_i);

   // ----------------------------------------
   // write side
   // ----------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // pointers and occupancy
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i || flush_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + AW'(1);
         if (load)
            rd_ptr <= rd_ptr + AW'(1);
         count <= count + CW'(push) - CW'(load);
      end
   end

   // ready registered from the occupancy it will have next
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i || flush_i)
         in_ready_o <= 1'b1;
      else
         in_ready_o <= (count + CW'(push) - CW'(load)) < CW'(DEPTH);
   end

   // ----------------------------------------
   // read side output register
   // ----------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i || flush_i)
      begin
         out_valid_o <= 1'b0;
         out_data_o <= '0;
      end
      else if (load)
      begin
         out_valid_o <= 1'b1;
         out_data_o <= mem[rd_ptr];
      end
      else if (out_ready_i)
      begin
         out_valid_o <= 1'b0;
      end
   end

   // level seen by software
   assign level_o = count;

   // never writes into a full store
   fifo_no_over_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      push |-> count < CW'(DEPTH))
      else $error("fifo written while full");
endmodule

// ---- asp_serial_port.sv ----
// converter output port: constants, then the core that decimates, buffers and serialises words
// assumes a 50 MHz system clock, synchronous inputs, and a modulator word offered on sample_i
//
// How it works
// - no frame marker before 816 settle periods
// - frame marker high exactly one master period
// - frame marker rises on master clock rise
// - bit clock rises on master clock rise
// - data launched on bit clock rising edge
// - inverted companion for clock, data, marker
// - reference select low picks internal reference
// - power down low stops all circuitry; here the register port keeps running
// - out-of-range pin flags overdriven input
// - input sampled fixed delay after clock rise
// - words are 16-bit two's complement
// - out-of-range output goes high on overrange
// - one result per 16 master periods
`timescale 1ns/10ps

package asp_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int SYS_CLK_MHZ = 50;                 // system clock rate
   localparam int SYS_PERIOD_NS = 1000 / SYS_CLK_MHZ;
   localparam int MCLK_DIV = 4;                     // system cycles per master period
   localparam int MCLK_MIN_PERIOD_NS = 50;          // shortest master period
   localparam int MCLK_MIN_CYC = (MCLK_MIN_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int APERTURE_CYC = 1;                 // sampling delay after master rise
   localparam int SYNC_MIN_MPER = 2;                // legal sync pulse, master periods
   localparam int SYNC_MAX_MPER = 16;
   localparam int SETTLE_MIN_MPER = 816;            // settling window after sync
   localparam int SETTLE_MAX_MPER = 832;
   localparam int DECIM = 16;                       // modulator words per result
   localparam int WORD_BITS = 16;
   localparam int FIFO_DEPTH = 8;
   // ----------------------------------------
   // registers
   // ----------------------------------------
   localparam logic [3:0] CTRL_ADDR = 4'h0;
   localparam logic [3:0] STATUS_ADDR = 4'h4;
   localparam int CTRL_OUT_EN_BIT = 0;              // serial output enable
   localparam int CTRL_SOFT_SYNC_BIT = 1;           // write one to resync
   localparam logic CTRL_OUT_EN_RESET = 1'b1;
   localparam int STAT_SETTLED_BIT = 0;
   localparam int STAT_OVR_BIT = 1;                 // sticky, write one to clear
   localparam int STAT_DROP_BIT = 2;                // sticky, write one to clear
   localparam int STAT_PD_BIT = 3;
   localparam int STAT_LEVEL_LSB = 4;
endpackage

module asp_serial_port #(
   parameter int MCLK_DIV = asp_pkg::MCLK_DIV,
   parameter int SETTLE_MPER = asp_pkg::SETTLE_MIN_MPER
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic sync_i,
   input wire logic [15:0] sample_i,
   input wire logic overrange_i,
   input wire logic internal_ref_select_n_i,
   input wire logic powerdown_n_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic sample_strobe_o,
   output logic bit_clk_o,
   output logic bit_clk_n_o,
   output logic ser_data_o,
   output logic ser_data_n_o,
   output logic frame_marker_out_o,
   output logic frame_marker_out_n_o,
   output logic overrange_flag_o,
   output logic int_ref_enable_o,
   output logic core_power_on_o
);
   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   localparam int PW = $clog2(MCLK_DIV);
   localparam int HALF = MCLK_DIV / 2;
   initial
   begin
      if (MCLK_DIV < asp_pkg::MCLK_MIN_CYC || MCLK_DIV < 2 || asp_pkg::APERTURE_CYC >= MCLK_DIV)
         $error("asp_serial_port: master period shorter than allowed");
      if (SETTLE_MPER > asp_pkg::SETTLE_MAX_MPER || SETTLE_MPER < 1)
         $error("asp_serial_port: settle count outside window");
   end

   // ----------------------------------------
   // master clock phase
   // ----------------------------------------
   logic [PW-1:0] ph;          // phase within a master period, 0 is the rising edge
   logic [PW-1:0] next_ph;
   logic tick_end;             // last system cycle of a master period
   logic pd;                   // power down requested
   logic out_en;               // software output enable
   logic soft_sync;            // one-cycle software resync
   logic resync;               // sync from pin or software
   logic [9:0] settle_cnt;     // master periods left until output is valid
   logic settled;

   assign pd = !powerdown_n_i;
   assign tick_end = (ph == PW'(MCLK_DIV - 1));
   assign next_ph = tick_end ? '0 : ph + PW'(1);
   assign resync = sync_i || soft_sync;
   assign settled = (settle_cnt == '0);

   // phase counter; in power down the whole core stands still
   // parked on the last phase, so the first bit clock rise after reset or power down starts a period
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i || pd)
         ph <= PW'(MCLK_DIV - 1);
      else
         ph <= next_ph;
   end

   // bit clock from master
   // high for the first half of each master period, rising with it
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i || pd)
         bit_clk_o <= 1'b0;
      else
         bit_clk_o <= (next_ph < PW'(HALF));
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i || pd)
         sample_strobe_o <= 1'b0;
      else
         sample_strobe_o <= (next_ph == PW'(asp_pkg::APERTURE_CYC));
   end

   // ----------------------------------------
   // sync and settling
   // ----------------------------------------
   // hold off output
   // sync restarts the decimator, buffer and serialiser but not the phase counter; the window restarts on every cycle the pin is high
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i || pd)
         settle_cnt <= 10'(SETTLE_MPER);
      else if (resync)
         settle_cnt <= 10'(SETTLE_MPER);
      else if (tick_end && !settled)
         settle_cnt <= settle_cnt - 10'h001;
   end

   // ----------------------------------------
   // decimator
   // ----------------------------------------
   logic [3:0] dec_cnt;                // modulator words taken this result
   logic signed [19:0] acc;            // running sum of sixteen signed words
   logic signed [19:0] sum;
   logic ovr_acc;                      // overrange seen during this result
   logic push;
   logic push_ready;
   logic [16:0] fifo_out;
   logic fifo_valid;
   logic pop;
   logic [3:0] level;

   assign sum = acc + 20'(signed'(sample_i));
   assign push = sample_strobe_o && (dec_cnt == 4'(asp_pkg::DECIM - 1)) && settled && !resync;

   // two's complement average
   // the mean of sixteen words keeps the full 7FFF..8000 span without saturation
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i || pd || resync)
      begin
         dec_cnt <= '0;
         acc <= '0;
         ovr_acc <= 1'b0;
      end
      else if (sample_strobe_o)
      begin
         dec_cnt <= dec_cnt + 4'h1;
         acc <= (dec_cnt == 4'(asp_pkg::DECIM - 1)) ? '0 : sum;
         ovr_acc <= (dec_cnt == 4'(asp_pkg::DECIM - 1)) ? 1'b0 : (ovr_acc || overrange_i);
      end
   end

   // words wait here; a full store drops the new word and flags it
   asp_fifo #(
      .WIDTH(17),
      .DEPTH(asp_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .flush_i(resync || pd),
      .in_data_i({ovr_acc || overrange_i, sum[19:4]}),
      .in_valid_i(push),
      .in_ready_o(push_ready),
      .out_data_o(fifo_out),
      .out_valid_o(fifo_valid),
      .out_ready_i(pop),
      .level_o(level)
   );

   // ----------------------------------------
   // serialiser
   // ----------------------------------------
   logic [15:0] shreg;          // remaining bits, msb leaves first
   logic [4:0] bits_left;       // bit periods left in this word, the one on the line included
   logic start;

   // a word starts only on a period boundary and when software allows output
   assign start = tick_end && bits_left <= 5'h01 && fifo_valid && out_en && settled;
   assign pop = start && !resync && !pd;

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i || pd || resync)
      begin
         shreg <= '0;
         bits_left <= '0;
         ser_data_o <= 1'b0;
      end
      else if (start)
      begin
         ser_data_o <= fifo_out[15];
         shreg <= {fifo_out[14:0], 1'b0};
         bits_left <= 5'(asp_pkg::WORD_BITS);
      end
      else if (tick_end && bits_left != '0)
      begin
         ser_data_o <= (bits_left > 5'h01) ? shreg[15] : 1'b0;
         shreg <= {shreg[14:0], 1'b0};
         bits_left <= bits_left - 5'h01;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i || pd || resync)
         frame_marker_out_o <= 1'b0;
      else if (tick_end)
         frame_marker_out_o <= start;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i || pd)
         overrange_flag_o <= 1'b0;
      else if (start)
         overrange_flag_o <= fifo_out[16];
   end

   // inverted companions
   // taken from the same next values so each pair switches together
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i || pd)
      begin
         bit_clk_n_o <= 1'b1;
         frame_marker_out_n_o <= 1'b1;
         ser_data_n_o <= 1'b1;
      end
      else
      begin
         bit_clk_n_o <= !(next_ph < PW'(HALF));
         frame_marker_out_n_o <= resync ? 1'b1 : (tick_end ? !start : frame_marker_out_n_o);
         ser_data_n_o <= resync ? 1'b1 : (start ? !fifo_out[15] :
            ((tick_end && bits_left != '0) ? !((bits_left > 5'h01) && shreg[15]) : ser_data_n_o));
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         int_ref_enable_o <= 1'b0;
         core_power_on_o <= 1'b0;
      end
      else
      begin
         int_ref_enable_o <= !internal_ref_select_n_i && !pd;
         core_power_on_o <= !pd;
      end
   end

   // ----------------------------------------
   // register port
   // ----------------------------------------
   logic ovr_seen;     // sticky overrange
   logic drop_seen;    // sticky lost word

   // control register
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         out_en <= asp_pkg::CTRL_OUT_EN_RESET;
         soft_sync <= 1'b0;
      end
      else
      begin
         soft_sync <= reg_wr_i && reg_addr_i == asp_pkg::CTRL_ADDR && reg_wdata_i[asp_pkg::CTRL_SOFT_SYNC_BIT];
         if (reg_wr_i && reg_addr_i == asp_pkg::CTRL_ADDR)
            out_en <= reg_wdata_i[asp_pkg::CTRL_OUT_EN_BIT];
      end
   end

   // sticky status: a new event wins over a clear in the same cycle
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         ovr_seen <= 1'b0;
         drop_seen <= 1'b0;
      end
      else
      begin
         if (start && fifo_out[16])
            ovr_seen <= 1'b1;
         else if (reg_wr_i && reg_addr_i == asp_pkg::STATUS_ADDR && reg_wdata_i[asp_pkg::STAT_OVR_BIT])
            ovr_seen <= 1'b0;
         if (push && !push_ready)
            drop_seen <= 1'b1;
         else if (reg_wr_i && reg_addr_i == asp_pkg::STATUS_ADDR && reg_wdata_i[asp_pkg::STAT_DROP_BIT])
            drop_seen <= 1'b0;
      end
   end

   // read data one cycle after the strobe, zero for unmapped addresses
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
         reg_rdata_o <= 8'h00;
      else if (reg_rd_i && reg_addr_i == asp_pkg::CTRL_ADDR)
         reg_rdata_o <= {7'h00, out_en};
      else if (reg_rd_i && reg_addr_i == asp_pkg::STATUS_ADDR)
         reg_rdata_o <= {level, pd, drop_seen, ovr_seen, settled};
      else
         reg_rdata_o <= 8'h00;
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);

   // marker width
   // a sync or power down cuts the marker and clears settled at the same edge
   frame_width_a: assert property ($rose(frame_marker_out_o) |-> (frame_marker_out_o || !settled)[*4]
      ##1 !frame_marker_out_o)
      else $error("frame marker not one master period");
   frame_edge_a: assert property ($rose(frame_marker_out_o) |-> ph == '0)
      else $error("frame marker rose off the master edge");
   bitclk_edge_a: assert property ($rose(bit_clk_o) |-> ph == '0)
      else $error("bit clock rose off the master edge");
   data_launch_a: assert property ($changed(ser_data_o) && !$past(resync) && !$past(pd) |->
      $rose(bit_clk_o))
      else $error("data changed away from bit clock rise");
   pair_inverse_a: assert property (!pd && !$past(pd) |-> bit_clk_n_o != bit_clk_o
      && ser_data_n_o != ser_data_o && frame_marker_out_n_o != frame_marker_out_o)
      else $error("companion output not inverted");
   // reference
   // the output keeps its reset value for one cycle after reset lets go
   ref_follow_a: assert property (!$past(pd) && !$past(sys_rst_i) |->
      int_ref_enable_o == !$past(internal_ref_select_n_i))
      else $error("reference select not followed");
   powerdown_quiet_a: assert property (pd ##1 pd |-> !core_power_on_o && !frame_marker_out_o && !bit_clk_o)
      else $error("core active while powered down");
   settle_quiet_a: assert property ($rose(frame_marker_out_o) |-> $past(settled))
      else $error("frame marker before settling");
   aperture_a: assert property (sample_strobe_o |-> ph == PW'(asp_pkg::APERTURE_CYC))
      else $error("sample strobe at wrong phase");
   overrange_word_a: assert property (start && fifo_out[16] && !pd |=> overrange_flag_o)
      else $error("overrange word without flag");

   frame_seen_c: cover property ($rose(frame_marker_out_o));
   overrange_seen_c: cover property ($rose(overrange_flag_o));
   sync_resettle_c: cover property ($fell(sync_i) ##[1:1000] settled);
   word_drop_c: cover property (push && !push_ready);
endmodule

// ---- asp_rx_model.sv ----
// receiver model: rebuilds words from the serial port pins
// assumes registered pins, all sampled on the system clock
`timescale 1ns/10ps

module asp_rx_model #(
   parameter int SETTLE_CYC = 80
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic sync_i,
   input wire logic powerdown_n_i,
   input wire logic bit_clk_i,
   input wire logic bit_clk_n_i,
   input wire logic ser_data_i,
   input wire logic ser_data_n_i,
   input wire logic marker_i,
   input wire logic marker_n_i,
   output logic [15:0] word_o,
   output logic [15:0] words_o,
   output logic [7:0] err_o
);
   logic bclk_q, data_q, mark_q; // pins one cycle back
   logic [15:0] settle_cnt; // cycles since sync let go
   logic [15:0] shift; // bits gathered so far
   logic [4:0] nbits; // bits still owed
   logic [3:0] mark_len; // marker high time
   logic [1:0] quiet; // checks held off after a restart
   logic fall, rise;
   assign fall = bclk_q && !bit_clk_i;
   assign rise = !bclk_q && bit_clk_i;

   // ----------------------------------------
   // capture and pin checks
   // ----------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      bclk_q <= bit_clk_i;
      data_q <= ser_data_i;
      mark_q <= marker_i;
      mark_len <= marker_i ? mark_len + 4'h1 : 4'h0;
      if (sys_rst_i)
      begin
         words_o <= 16'h0000;
         err_o <= 8'h00;
         word_o <= 16'h0000;
      end
      // a restart drops any half word and reopens the settle wait
      if (sys_rst_i || sync_i || !powerdown_n_i)
      begin
         settle_cnt <= 16'h0000;
         quiet <= 2'h3;
         nbits <= 5'h00;
      end
      else
      begin
         if (settle_cnt != 16'hFFFF)
            settle_cnt <= settle_cnt + 16'h0001;
         if (quiet != 2'h0)
            quiet <= quiet - 2'h1;
         if (fall && marker_i && settle_cnt >= 16'(SETTLE_CYC))
         begin
            shift <= {15'h0000, ser_data_i};
            nbits <= 5'h0F;
         end
         else if (fall && nbits != 5'h00)
         begin
            shift <= {shift[14:0], ser_data_i};
            nbits <= nbits - 5'h01;
            if (nbits == 5'h01)
            begin
               word_o <= {shift[14:0], ser_data_i};
               words_o <= words_o + 16'h0001;
            end
         end
         if (quiet == 2'h0)
         begin
            if (bit_clk_n_i == bit_clk_i || ser_data_n_i == ser_data_i || marker_n_i == marker_i)
               err_o <= err_o + 8'h01;
            else if (ser_data_i != data_q && !rise)
               err_o <= err_o + 8'h01;
            else if (marker_i && !mark_q && !rise)
               err_o <= err_o + 8'h01;
            else if (!marker_i && mark_q && mark_len != 4'h4)
               err_o <= err_o + 8'h01;
         end
      end
   end
endmodule

// ---- asp_serial_port_tb.sv ----
// bench: words, overrange, reference, power down, sync and buffer checks
// assumes the receiver model is compiled first
`timescale 1ns/10ps

module asp_serial_port_tb;
   localparam int SETTLE = 20; // short settle keeps the run brief
   logic clk_sys_i, sys_rst_i, sync_i, ovr_in, ref_n, pd_n, reg_wr, reg_rd, b;
   logic [15:0] sample, v, start;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rd;
   logic bclk, bclk_n, sdat, sdat_n, mark, mark_n, ovr_flag, int_ref, pwr_on, strobe;
   logic [15:0] rx_word, rx_count;
   logic [7:0] rx_err;
   int n_mismatch, compares, cnt;

   // four system cycles make an 80 ns master period
   asp_serial_port #(.MCLK_DIV(4), .SETTLE_MPER(SETTLE)) asp_serial_port_i (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .sync_i(sync_i), .sample_i(sample),
      .overrange_i(ovr_in), .internal_ref_select_n_i(ref_n), .powerdown_n_i(pd_n),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_rdata_o(reg_rdata), .sample_strobe_o(strobe), .bit_clk_o(bclk), .bit_clk_n_o(bclk_n),
      .ser_data_o(sdat), .ser_data_n_o(sdat_n), .frame_marker_out_o(mark),
      .frame_marker_out_n_o(mark_n), .overrange_flag_o(ovr_flag), .int_ref_enable_o(int_ref),
      .core_power_on_o(pwr_on));

   asp_rx_model #(.SETTLE_CYC(SETTLE * 4)) asp_rx_model_i (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .sync_i(sync_i), .powerdown_n_i(pd_n),
      .bit_clk_i(bclk), .bit_clk_n_i(bclk_n), .ser_data_i(sdat), .ser_data_n_i(sdat_n),
      .marker_i(mark), .marker_n_i(mark_n), .word_o(rx_word), .words_o(rx_count), .err_o(rx_err));

   // ----------------------------------------
   // clock and helpers
   // ----------------------------------------
   initial
   begin
      clk_sys_i = 1'h0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // one write: strobe high for a single cycle
   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk_sys_i);
      reg_wr <= 1'h0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [3:0] a);
      @(posedge clk_sys_i);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk_sys_i);
      reg_rd <= 1'h0;
      #1 rd = reg_rdata;
   endtask

   // bounded wait for whole words at the receiver
   task automatic wait_words(input int n);
      int lim;
      start = rx_count;
      lim = n * 64 + 400;
      while (16'(rx_count - start) < n && lim > 0)
      begin
         @(posedge clk_sys_i);
         lim--;
      end
      if (16'(rx_count - start) < n)
      begin
         check("word wait", 0, 1);
         close_out();
      end
   endtask

   // a held input decimated by 16 must give itself back
   function automatic logic [15:0] avg16(input logic [15:0] x);
      logic signed [19:0] s;
      s = 20'h00000;
      for (int k = 0; k < 16; k++)
         s = s + $signed({{4{x[15]}}, x});
      return s[19:4];
   endfunction

   initial
   begin
      repeat (100000) @(posedge clk_sys_i);
      check("run time", 0, 1);
      close_out();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      sys_rst_i = 1'h1;
      sync_i = 1'h0;
      ovr_in = 1'h0;
      ref_n = 1'h0;
      pd_n = 1'h1;
      sample = 16'h0000;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      n_mismatch = 0;
      compares = 0;
      void'($urandom(62604));
      repeat (16) @(posedge clk_sys_i);
      sys_rst_i <= 1'h0;
      reg_read(asp_pkg::CTRL_ADDR);
      check("ctrl reset", rd, 8'h01);
      reg_read(4'hF);
      check("unmapped read", rd, 8'h00);
      $display("test registers done");
      // corner codes first, then random ones
      for (int k = 0; k < 6; k++)
      begin
         v = (k == 0) ? 16'h7FFF : (k == 1) ? 16'h8000 : 16'($urandom);
         @(posedge clk_sys_i);
         sample <= v;
         wait_words(4);
         check("word", rx_word, avg16(v));
      end
      cnt = 0;
      repeat (64)
      begin
         @(posedge clk_sys_i);
         #1 cnt += strobe;
      end
      check("strobes per word", cnt, 16);
      $display("test words done");
      @(posedge clk_sys_i);
      ovr_in <= 1'h1;
      wait_words(3);
      check("overrange high", ovr_flag, 1);
      ovr_in <= 1'h0;
      wait_words(3);
      check("overrange low", ovr_flag, 0);
      reg_read(asp_pkg::STATUS_ADDR);
      check("status low bits", rd & 8'h0F, 8'h03);
      reg_write(asp_pkg::STATUS_ADDR, 8'h02);
      reg_read(asp_pkg::STATUS_ADDR);
      check("overrange cleared", rd[1], 0);
      $display("test overrange done");
      for (int k = 0; k < 4; k++)
      begin
         b = 1'($urandom);
         @(posedge clk_sys_i);
         ref_n <= b;
         repeat (2) @(posedge clk_sys_i);
         #1 check("reference", int_ref, !b);
      end
      @(posedge clk_sys_i);
      pd_n <= 1'h0;
      repeat (8) @(posedge clk_sys_i);
      #1 check("powered", pwr_on, 0);
      check("pins idle", {bclk, bclk_n, mark_n, int_ref}, 4'h6);
      reg_read(asp_pkg::STATUS_ADDR);
      check("status power down", rd[3], 1);
      @(posedge clk_sys_i);
      pd_n <= 1'h1;
      repeat (2) @(posedge clk_sys_i);
      #1 check("power back", pwr_on, 1);
      $display("test power down done");
      // shortest and longest legal sync pulses
      for (int k = 0; k < 2; k++)
      begin
         @(posedge clk_sys_i);
         sync_i <= 1'h1;
         repeat (k ? 64 : 8) @(posedge clk_sys_i);
         sync_i <= 1'h0;
         cnt = 0;
         while (!mark && cnt < (SETTLE + 20) * 4)
         begin
            @(posedge clk_sys_i);
            #1 cnt++;
         end
         check("settle lower", cnt >= SETTLE * 4, 1);
         check("settle upper", cnt < (SETTLE + 20) * 4, 1);
         wait_words(2);
         check("word after sync", rx_word, avg16(v));
      end
      check("receiver faults", rx_err, 0);
      $display("test sync done");
      // output off: the buffer fills and then drops
      reg_write(asp_pkg::CTRL_ADDR, 8'h00);
      repeat (64) @(posedge clk_sys_i);
      start = rx_count;
      repeat (704) @(posedge clk_sys_i);
      check("no words while off", rx_count, start);
      reg_read(asp_pkg::STATUS_ADDR);
      check("buffer full", rd & 8'hF4, 8'h84);
      reg_write(asp_pkg::CTRL_ADDR, 8'h01);
      wait_words(3);
      check("stale words", rx_word, avg16(v));
      // software resync empties the buffer and reopens the settle wait
      reg_write(asp_pkg::CTRL_ADDR, 8'h03);
      reg_read(asp_pkg::STATUS_ADDR);
      check("soft sync", rd & 8'hF1, 8'h00);
      @(posedge clk_sys_i);
      sync_i <= 1'h1;
      repeat (8) @(posedge clk_sys_i);
      sync_i <= 1'h0;
      // drop cleared only once a full buffer can no longer overflow
      reg_write(asp_pkg::STATUS_ADDR, 8'h04);
      reg_read(asp_pkg::STATUS_ADDR);
      check("flushed", rd & 8'hF4, 8'h00);
      $display("test buffer done");
      close_out();
   end
endmodule
